/* File: src/nvsp_pkg.sv */
package nvsp_pkg;
    localparam int NVSP_CLK_MHZ = 100;
    localparam int NVSP_AW = 17;
    localparam int NVSP_DW = 16;
    localparam int NVSP_LANE_W = 8;
    localparam int NVSP_SEQ_LEN = 6;
    // read and write strobe time, ns
    localparam int NVSP_STROBE_NS = 20;
    localparam int NVSP_STROBE_CYC = (NVSP_STROBE_NS * NVSP_CLK_MHZ + 999) / 1000;
    // hardware store pulse width, ns (least)
    localparam int NVSP_HSB_PULSE_NS = 15;
    localparam int NVSP_HSB_PULSE_CYC = (NVSP_HSB_PULSE_NS * NVSP_CLK_MHZ + 999) / 1000;
    // soft sequence processing time, us
    localparam int NVSP_SS_US = 100;
    localparam int NVSP_SS_CYC = NVSP_SS_US * NVSP_CLK_MHZ;
    // store cycle duration, ms
    localparam int NVSP_STORE_MS = 8;
    localparam int NVSP_STORE_CYC = NVSP_STORE_MS * 1000 * NVSP_CLK_MHZ;
    localparam int NVSP_CNT_W = 20;

    typedef enum logic [1:0] {
        NVSP_CMD_READ = 2'h0,
        NVSP_CMD_WRITE = 2'h1,
        NVSP_CMD_SOFT = 2'h2,
        NVSP_CMD_HWSTORE = 2'h3
    } nvsp_cmd_t;

    typedef struct packed {
        nvsp_cmd_t cmd;
        logic [NVSP_AW-1:0] addr;
        logic [NVSP_DW-1:0] wdata;
        logic [1:0] lane_en;
    } nvsp_req_t;

    typedef struct packed {
        logic chip_select_n;
        logic write_strobe_n;
        logic output_gate_n;
        logic upper_byte_en_n;
        logic lower_byte_en_n;
        logic [NVSP_AW-1:0] addr;
    } nvsp_pins_t;
endpackage

/* File: src/nvsp_host.sv */
// Function
// R1 - each soft command step is a full read cycle strobed by chip select
// R2 - soft command reads the six table addresses in order, nothing interleaved
// R3 - write strobe stays high through all six soft command reads
// R4 - hardware store request holds hw_store_busy_n low for the minimum pulse
// R5 - device releases busy quickly when write latch is clear
// R6 - device acts on soft command within processing time; host waits it out
// R7 - data lines blocked while commit or restore runs
// R8 - hw_store_busy_n stays high during ordinary reads and writes
// R9 - chip select high floats data lines and puts device in standby
// R10 - read drives eight bits in byte mode or sixteen with both enables
// R11 - word read drives only the enabled lane
// R12 - selected with both strobes high, data lines float
// R13 - write strobe low with chip select low writes regardless of output gate
// R14 - word write with both enables stores sixteen bits
// R15 - single enabled lane write updates only that lane
// R16 - hardware commit skipped if no write since last nonvolatile operation
// R17 - device ignores host cycles during commit or restore
// R18 - commit completes within its maximum duration
// R19 - command addresses form a parameter table per command
// R20 - broken sequence restarts the tracker at step one
`timescale 1ns/1ns
module nvsp_host
    import nvsp_pkg::*;
#(
    parameter int STORE_WAIT = NVSP_STORE_CYC,
    parameter int SS_WAIT = NVSP_SS_CYC,
    parameter logic [NVSP_SEQ_LEN*NVSP_AW-1:0] SEQ_TABLE = {NVSP_SEQ_LEN{17'h00000}}
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire nvsp_pkg::nvsp_req_t req,
    input wire logic req_valid,
    output logic req_ready,
    output logic [nvsp_pkg::NVSP_DW-1:0] rdata,
    output logic rdata_valid,
    output nvsp_pkg::nvsp_pins_t pins,
    input wire logic [nvsp_pkg::NVSP_DW-1:0] data_in,
    output logic [nvsp_pkg::NVSP_DW-1:0] data_out,
    output logic data_oe,
    input wire logic hw_store_busy_n_in,
    output logic hw_store_busy_n_out,
    output logic hw_store_busy_n_oe
);
    import nvsp_pkg::*;

    // wait counters are NVSP_CNT_W wide, a longer wait would wrap and end early
    if (STORE_WAIT < 1 || STORE_WAIT >= (1 << NVSP_CNT_W) || SS_WAIT < 1 || SS_WAIT >= (1 << NVSP_CNT_W))
    begin
        $error("wait counts out of counter range");
    end

    typedef enum logic [5:0] {
        NVSP_ST_IDLE = 6'h01,
        NVSP_ST_STROBE = 6'h02,
        NVSP_ST_GAP = 6'h04,
        NVSP_ST_HSB = 6'h08,
        NVSP_ST_BUSY = 6'h10,
        NVSP_ST_WAIT = 6'h20
    } nvsp_state_t;

    nvsp_state_t state, next_state;
    nvsp_req_t cur, next_cur;
    nvsp_pins_t next_pins;
    logic [NVSP_CNT_W-1:0] cnt, next_cnt;
    logic [2:0] step, next_step;
    logic [NVSP_DW-1:0] next_rdata, next_data_out;
    logic next_rdata_valid, next_data_oe, next_hsb_oe;

    localparam nvsp_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, {NVSP_AW{1'b0}}};
    localparam logic [NVSP_CNT_W-1:0] STROBE_CNT = NVSP_CNT_W'(NVSP_STROBE_CYC);
    localparam logic [NVSP_CNT_W-1:0] HSB_CNT = NVSP_CNT_W'(NVSP_HSB_PULSE_CYC);
    localparam logic [2:0] LAST_STEP = 3'(NVSP_SEQ_LEN - 1);

    assign req_ready = (state == NVSP_ST_IDLE) && clk_en;
    assign hw_store_busy_n_out = 1'b0;

    always_comb
    begin
        next_state = state;
        next_cur = cur;
        next_pins = pins;
        next_cnt = cnt;
        next_step = step;
        next_rdata = rdata;
        next_rdata_valid = 1'b0;
        next_data_out = data_out;
        next_data_oe = data_oe;
        next_hsb_oe = hw_store_busy_n_oe;
        case (state)
            NVSP_ST_IDLE:
            begin
                if (req_valid)
                begin
                    next_cur = req;
                    next_step = 3'h0;
                    next_cnt = STROBE_CNT;
                    if (req.cmd == NVSP_CMD_HWSTORE)
                    begin
                        next_hsb_oe = 1'b1; // R4
                        next_cnt = HSB_CNT;
                        next_state = NVSP_ST_HSB;
                    end
                    else
                    begin
                        next_state = NVSP_ST_STROBE;
                        next_pins.chip_select_n = 1'b0; // R1
                        next_pins.upper_byte_en_n = ~req.lane_en[1];
                        next_pins.lower_byte_en_n = ~req.lane_en[0];
                        if (req.cmd == NVSP_CMD_WRITE)
                        begin
                            next_pins.addr = req.addr;
                            next_pins.write_strobe_n = 1'b0; // R13
                            next_data_out = req.wdata; // R14 R15
                            next_data_oe = 1'b1;
                        end
                        else if (req.cmd == NVSP_CMD_SOFT)
                        begin
                            next_pins.addr = SEQ_TABLE[(NVSP_SEQ_LEN-1)*NVSP_AW +: NVSP_AW]; // R2 R19
                            next_pins.output_gate_n = 1'b0; // R3
                        end
                        else
                        begin
                            next_pins.addr = req.addr;
                            next_pins.output_gate_n = 1'b0; // R10 R11
                        end
                    end
                end
            end
            NVSP_ST_STROBE:
            begin
                next_cnt = cnt - 1'b1;
                if (cnt == 1)
                begin
                    if (cur.cmd != NVSP_CMD_WRITE)
                    begin
                        next_rdata = data_in;
                        next_rdata_valid = cur.cmd == NVSP_CMD_READ;
                    end
                    next_pins = PINS_IDLE; // R9
                    next_pins.addr = pins.addr;
                    next_data_oe = 1'b0;
                    next_state = NVSP_ST_GAP;
                end
            end
            NVSP_ST_GAP:
            begin
                if (cur.cmd == NVSP_CMD_SOFT && step != LAST_STEP)
                begin
                    next_step = step + 3'h1;
                    next_cnt = STROBE_CNT;
                    next_pins.chip_select_n = 1'b0; // R1
                    next_pins.output_gate_n = 1'b0;
                    next_pins.addr = SEQ_TABLE[(NVSP_SEQ_LEN-2-32'(step))*NVSP_AW +: NVSP_AW]; // R2
                    next_state = NVSP_ST_STROBE;
                end
                else if (cur.cmd == NVSP_CMD_SOFT)
                begin
                    next_cnt = NVSP_CNT_W'(SS_WAIT); // R6
                    next_state = NVSP_ST_WAIT;
                end
                else
                    next_state = NVSP_ST_IDLE;
            end
            NVSP_ST_HSB:
            begin
                next_cnt = cnt - 1'b1;
                if (cnt == 1)
                begin
                    next_hsb_oe = 1'b0;
                    next_cnt = NVSP_CNT_W'(STORE_WAIT); // R18
                    next_state = NVSP_ST_BUSY;
                end
            end
            NVSP_ST_BUSY:
            begin
                // device holds busy low while committing; releases early if latch clear
                next_cnt = cnt - 1'b1;
                if (hw_store_busy_n_in || cnt == 1) // R5 R16
                    next_state = NVSP_ST_IDLE;
            end
            NVSP_ST_WAIT:
            begin
                // no access during lockout, device would ignore it
                next_cnt = cnt - 1'b1;
                if (cnt == 1) // R7 R17
                    next_state = NVSP_ST_IDLE;
            end
            default:
                next_state = NVSP_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state <= NVSP_ST_IDLE;
            cur <= '0;
            pins <= PINS_IDLE;
            cnt <= '0;
            step <= 3'h0;
            rdata <= '0;
            rdata_valid <= 1'b0;
            data_out <= '0;
            data_oe <= 1'b0;
            hw_store_busy_n_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            state <= next_state;
            cur <= next_cur;
            pins <= next_pins;
            cnt <= next_cnt;
            step <= next_step;
            rdata <= next_rdata;
            rdata_valid <= next_rdata_valid;
            data_out <= next_data_out;
            data_oe <= next_data_oe;
            hw_store_busy_n_oe <= next_hsb_oe;
        end
    end

    sequence soft_read_s;
        !pins.chip_select_n && pins.write_strobe_n;
    endsequence

    AST_WE_HIGH_SOFT: assert property (@(posedge clk) disable iff (!reset_n) // R3
        (cur.cmd == NVSP_CMD_SOFT && state == NVSP_ST_STROBE) |-> soft_read_s)
        else $error("write strobe low during soft sequence");
    AST_HSB_IDLE_ACCESS: assert property (@(posedge clk) disable iff (!reset_n) // R8
        !pins.chip_select_n |-> !hw_store_busy_n_oe)
        else $error("busy driven during access");
    AST_HSB_PULSE: assert property (@(posedge clk) disable iff (!reset_n) // R4
        $rose(hw_store_busy_n_oe) |-> hw_store_busy_n_oe [*2])
        else $error("store pulse too short");
    AST_NO_DRIVE_READ: assert property (@(posedge clk) disable iff (!reset_n) // R12
        !pins.output_gate_n |-> !data_oe)
        else $error("host drives data during read");
    AST_DESELECT_FLOAT: assert property (@(posedge clk) disable iff (!reset_n) // R9
        pins.chip_select_n |-> !data_oe)
        else $error("data driven while deselected");
    AST_WRITE_DATA: assert property (@(posedge clk) disable iff (!reset_n) // R13
        !pins.write_strobe_n |-> data_oe && !pins.chip_select_n)
        else $error("write without data");
    AST_SOFT_NO_ACCESS: assert property (@(posedge clk) disable iff (!reset_n) // R17
        state == NVSP_ST_WAIT |-> pins.chip_select_n)
        else $error("access during lockout");
    AST_STROBE_LEN: assert property (@(posedge clk) disable iff (!reset_n) // R1
        (clk_en && $fell(pins.chip_select_n)) |-> !pins.chip_select_n [*2])
        else $error("strobe too short");
endmodule

/* File: dv/nvsp_dev.sv */
`timescale 1ns/1ns
module nvsp_dev
    import nvsp_pkg::*;
#(
    parameter logic [NVSP_SEQ_LEN*NVSP_AW-1:0] SEQ_TABLE = '0,
    parameter int LOCK_CYC = 6,
    parameter int STORE_LOCK = 12
)
(
    input wire logic clk,
    input wire nvsp_pkg::nvsp_pins_t pins,
    input wire logic [nvsp_pkg::NVSP_DW-1:0] dq_in,
    input wire logic busy_n,
    output logic [nvsp_pkg::NVSP_DW-1:0] dq_out,
    output logic [1:0] dq_oe,
    output logic busy_oe,
    output int commits = 0,
    output int softs = 0
);
    // only 256 words modelled, the bench keeps addresses small
    logic [NVSP_DW-1:0] mem [0:255];
    logic latch = 1'b0;
    logic busy_q = 1'b0;
    logic hw = 1'b0;
    logic strobe_q = 1'b1;
    logic [NVSP_AW-1:0] addr_q = '0;
    int step = 0;
    int lock = 0;
    wire rd = !pins.chip_select_n && pins.write_strobe_n && !pins.output_gate_n;
    assign dq_out = mem[pins.addr[7:0]];
    assign dq_oe = (rd && lock == 0) ? ~{pins.upper_byte_en_n, pins.lower_byte_en_n} : 2'b00;
    assign busy_oe = hw && lock > 0;
    always @(posedge clk)
    begin
        strobe_q <= pins.chip_select_n | pins.output_gate_n;
        busy_q <= !busy_n;
        if (!strobe_q)
            addr_q <= pins.addr;
        if (lock > 0)
            lock <= lock - 1;
        else if (!busy_n && !busy_q && latch)
        begin
            hw <= 1'b1;
            lock <= STORE_LOCK;
            latch <= 1'b0;
            commits <= commits + 1;
        end
        else if (!pins.chip_select_n && !pins.write_strobe_n)
        begin
            if (!pins.upper_byte_en_n)
                mem[pins.addr[7:0]][15:8] <= dq_in[15:8];
            if (!pins.lower_byte_en_n)
                mem[pins.addr[7:0]][7:0] <= dq_in[7:0];
            latch <= 1'b1;
            step <= 0;
        end
        else if (!strobe_q && (pins.chip_select_n | pins.output_gate_n))
        begin
            hw <= 1'b0;
            if (addr_q == SEQ_TABLE[(5 - step) * NVSP_AW +: NVSP_AW] && step == 5)
            begin
                step <= 0;
                lock <= LOCK_CYC;
                latch <= 1'b0;
                softs <= softs + 1;
            end
            else if (addr_q == SEQ_TABLE[(5 - step) * NVSP_AW +: NVSP_AW])
                step <= step + 1;
            else
                step <= (addr_q == SEQ_TABLE[5 * NVSP_AW +: NVSP_AW]) ? 1 : 0;
        end
    end
endmodule

/* File: dv/nvsp_host_bench.sv */
`timescale 1ns/1ns
module nvsp_host_bench;
    import nvsp_pkg::*;
    // arbitrary command addresses, one distinct value per step
    localparam logic [NVSP_SEQ_LEN*NVSP_AW-1:0] TBL = {17'h10a51, 17'h10b62, 17'h10c73,
        17'h10d84, 17'h10e95, 17'h10fa6};
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    nvsp_req_t req = '0;
    logic req_valid = 1'b0;
    logic req_ready, rdata_valid, data_oe, busy_oe_h, busy_out, busy_oe_d;
    logic [NVSP_DW-1:0] rdata, data_out, dq_dev, data_in;
    logic [NVSP_DW-1:0] flt = 16'h5a5a;
    logic [1:0] dq_oe;
    logic [31:0] e;
    nvsp_pins_t pins;
    int commits, softs, n;
    int miscompares = 0;
    int checked = 0;
    logic [NVSP_DW-1:0] shadow [0:255];
    logic [31:0] expq [$];
    always #5 clk = ~clk;
    // released lanes toggle so a stale value never passes
    always @(posedge clk) flt <= ~flt;
    assign data_in = data_oe ? data_out : {dq_oe[1] ? dq_dev[15:8] : flt[15:8], dq_oe[0] ? dq_dev[7:0] : flt[7:0]};
    wire busy_pin = !(busy_oe_h && !busy_out) && !busy_oe_d;
    nvsp_host #(.STORE_WAIT(20), .SS_WAIT(10), .SEQ_TABLE(TBL)) dut_u (.clk(clk), .reset_n(reset_n), .clk_en(1'b1),
        .req(req), .req_valid(req_valid), .req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid),
        .pins(pins), .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .hw_store_busy_n_in(busy_pin),
        .hw_store_busy_n_out(busy_out), .hw_store_busy_n_oe(busy_oe_h));
    nvsp_dev #(.SEQ_TABLE(TBL)) dev_u (.clk(clk), .pins(pins), .dq_in(data_in), .busy_n(busy_pin), .dq_out(dq_dev),
        .dq_oe(dq_oe), .busy_oe(busy_oe_d), .commits(commits), .softs(softs));
    task automatic summarize;
        if (miscompares == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [NVSP_DW-1:0] seen, input logic [NVSP_DW-1:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic issue(input nvsp_cmd_t cmd, input logic [7:0] a, input logic [15:0] d, input logic [1:0] en);
        int t;
        t = 0;
        req <= '{cmd: cmd, addr: 17'(a), wdata: d, lane_en: en};
        req_valid <= 1'b1;
        do
        begin
            @(posedge clk);
            t++;
        end
        while (req_ready !== 1'b1 && t < 100);
        check(16'(t < 100), 16'h0001);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] en);
        if (en[1])
            shadow[a][15:8] = d[15:8];
        if (en[0])
            shadow[a][7:0] = d[7:0];
        issue(NVSP_CMD_WRITE, a, d, en);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] en);
        logic [15:0] m;
        m = {{8{en[1]}}, {8{en[0]}}};
        expq.push_back({m, shadow[a] & m});
        issue(NVSP_CMD_READ, a, 16'h0000, en);
    endtask
    task automatic hw(input int want, input int lo, input int hi);
        int t;
        issue(NVSP_CMD_HWSTORE, 8'h00, 16'h0000, 2'b00);
        req_valid <= 1'b0;
        t = 0;
        @(posedge clk);
        while (req_ready !== 1'b1 && t < 100)
        begin
            @(posedge clk);
            t++;
        end
        check(16'(commits), 16'(want));
        check(16'(t >= lo && t <= hi), 16'h0001);
    endtask
    always @(posedge clk)
        if (rdata_valid === 1'b1)
        begin
            // an unexpected read result can never match the fallback note
            e = expq.size() > 0 ? expq.pop_front() : 32'h0000_0001;
            check(rdata & e[31:16], e[15:0]);
        end
    initial
    begin
        #200000;
        miscompares++;
        summarize();
    end
    initial
    begin
        n = $urandom(50120);
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 16; i++)
            wr(8'(i), 16'($urandom), 2'b11);
        for (int i = 0; i < 80; i++)
            if ($urandom % 2)
                wr(8'($urandom % 16), 16'($urandom), 2'($urandom % 3 + 1));
            else
                rd(8'($urandom % 16), 2'($urandom % 3 + 1));
        issue(NVSP_CMD_SOFT, 8'h00, 16'h0000, 2'b00);
        for (int i = 0; i < 16; i++)
            rd(8'(i), 2'b11);
        req_valid <= 1'b0;
        repeat (6) @(posedge clk);
        check(16'(softs), 16'h0001);
        hw(0, 0, 8);
        wr(8'h03, 16'(~shadow[3]), 2'b11);
        hw(1, 12, 24);
        hw(1, 0, 8);
        rd(8'h03, 2'b11);
        req_valid <= 1'b0;
        repeat (8) @(posedge clk);
        check(16'(expq.size()), 16'h0000);
        summarize();
    end
endmodule
